// >>> hdl/hgcs_pkg.sv
// constants, register map and encodings of the general configuration and status bank
// Summary of operation
// - I2C controller enable follows bit 5, reset 0.
// - mode 0, no assigned lock: port high impedance.
// - mode 1, no lock, sleep select 1, drive 1: port idles in LP-11.
// - sleep select 1, drive 0: outputs high impedance.
// - mode 1, sleep select 0, lock low: outputs HS-0.
// - receiver parity check follows bit 1 (reset 1); the output is 0 until the first clock after reset.
// - override bit forces reference clock present.
// - revision in 7:4, mask 0x0 in 3:0.
// - checksum pass resets to 1, then after each load it is set only for a valid ROM checksum.
// - init done set when ROM load finishes.
// - clock valid only for 12 to 64 MHz.
// - reload trigger restarts ROM load, done polls completion.
package hgcs_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] HGCS_OFS_GENERAL_CONFIGURATION = 8'h02;
    localparam logic [7:0] HGCS_OFS_SILICON_REVISION      = 8'h03;
    localparam logic [7:0] HGCS_OFS_DEVICE_STATUS         = 8'h04;

    localparam logic [7:0] HGCS_RST_GENERAL_CONFIGURATION = 8'h1E;
    localparam logic [7:0] HGCS_RST_DEVICE_STATUS         = 8'hC0;
    localparam logic [5:0] HGCS_CFG_WRITE_MASK            = 6'h3F;

    // general configuration field positions
    localparam int HGCS_BIT_I2C_CTRL_EN   = 5;
    localparam int HGCS_BIT_LOCK_OUT_MODE = 4;
    localparam int HGCS_BIT_TX_DRIVE      = 3;
    localparam int HGCS_BIT_SLEEP_SEL     = 2;
    localparam int HGCS_BIT_PARITY_EN     = 1;
    localparam int HGCS_BIT_REF_OVERRIDE  = 0;

    // device status field positions
    localparam int HGCS_BIT_CKSUM_PASS = 7;
    localparam int HGCS_BIT_INIT_DONE  = 6;
    localparam int HGCS_BIT_REF_FREQ   = 4;

    // silicon revision register: value is arbitrary, mask set fixed
    localparam logic [3:0] HGCS_SILICON_REVISION_FIELD = 4'hA;
    localparam logic [3:0] HGCS_MASK_SET_FIELD         = 4'h0;

    // ****************************************************************
    // timing of the reference clock frequency check
    // ****************************************************************
    localparam int HGCS_MCLK_PERIOD_NS  = 50;
    localparam int HGCS_REF_WINDOW_NS   = 50000;
    localparam int HGCS_REF_WINDOW_CYC  = HGCS_REF_WINDOW_NS / HGCS_MCLK_PERIOD_NS;
    localparam int HGCS_REF_PRESCALE    = 16;
    localparam int HGCS_REF_MIN_MHZ     = 12;
    localparam int HGCS_REF_MAX_MHZ     = 64;
    localparam int HGCS_REF_MIN_EDGES   =
        (HGCS_REF_MIN_MHZ * HGCS_REF_WINDOW_NS) / (1000 * HGCS_REF_PRESCALE);
    localparam int HGCS_REF_MAX_EDGES   =
        (HGCS_REF_MAX_MHZ * HGCS_REF_WINDOW_NS) / (1000 * HGCS_REF_PRESCALE);
    localparam int HGCS_WIN_W           = 10;
    localparam int HGCS_EDGE_W          = 9;

    // ****************************************************************
    // encodings
    // ****************************************************************
    typedef enum logic [1:0]
    {
        HGCS_TX_NORMAL = 2'h0,
        HGCS_TX_LP11   = 2'h1,
        HGCS_TX_HS0    = 2'h2,
        HGCS_TX_HIZ    = 2'h3
    } hgcs_tx_state_t;

    typedef enum logic [2:0]
    {
        HGCS_LD_START = 3'h1,
        HGCS_LD_WAIT  = 3'h2,
        HGCS_LD_DONE  = 3'h4
    } hgcs_load_state_t;

endpackage

// >>> hdl/hgcs_ref_freq_check.sv
// reference clock frequency window checker
`timescale 1ns/1ps
module hgcs_ref_freq_check
    import hgcs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ref_div_toggle,
    output logic      freq_ok
);

    // ****************************************************************
    // edge count over a fixed window
    // ****************************************************************
    // the pin is pre-divided by the prescale so 64 MHz stays below half of mclk
    logic [HGCS_WIN_W-1:0]  win_q,  win_d;
    logic [HGCS_EDGE_W-1:0] edge_q, edge_d;
    logic                   tgl_q,  tgl_d;
    logic                   ok_q,   ok_d;

    localparam logic [HGCS_WIN_W-1:0]  WIN_LAST  = HGCS_WIN_W'(HGCS_REF_WINDOW_CYC - 1);
    localparam logic [HGCS_EDGE_W-1:0] EDGE_MIN  = HGCS_EDGE_W'(HGCS_REF_MIN_EDGES);
    localparam logic [HGCS_EDGE_W-1:0] EDGE_MAX  = HGCS_EDGE_W'(HGCS_REF_MAX_EDGES);
    localparam logic [HGCS_EDGE_W-1:0] EDGE_SAT  = {HGCS_EDGE_W{1'b1}};

    always_comb
    begin
        tgl_d  = ref_div_toggle;
        win_d  = win_q + HGCS_WIN_W'(1);
        edge_d = edge_q;
        ok_d   = ok_q;
        if ((tgl_q != ref_div_toggle) && (edge_q != EDGE_SAT))
        begin
            edge_d = edge_q + HGCS_EDGE_W'(1);
        end
        if (win_q == WIN_LAST)
        begin
            win_d  = '0;
            edge_d = '0;
            ok_d   = (edge_q >= EDGE_MIN) && (edge_q <= EDGE_MAX);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_q  <= '0;
            edge_q <= '0;
            tgl_q  <= 1'b0;
            ok_q   <= 1'b0;
        end
        else
        begin
            win_q  <= win_d;
            edge_q <= edge_d;
            tgl_q  <= tgl_d;
            ok_q   <= ok_d;
        end
    end

    assign freq_ok = ok_q;

endmodule

// >>> hdl/hgcs_top.sv
// general configuration, revision and device status register bank
`timescale 1ns/1ps
module hgcs_top
    import hgcs_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       NRST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    input  wire logic       ROM_RELOAD_TRIGGER,
    output logic            ROM_LOAD_REQ,
    input  wire logic       ROM_LOAD_DONE,
    input  wire logic       ROM_CKSUM_OK,
    input  wire logic [3:0] RX_LOCK,
    input  wire logic [3:0] TX0_RX_ASSIGN,
    input  wire logic [3:0] TX1_RX_ASSIGN,
    output logic      [1:0] TX0_STATE,
    output logic      [1:0] TX1_STATE,
    output logic            I2C_CTRL_EN,
    output logic            PARITY_CHECK_EN,
    input  wire logic       REF_DETECTED,
    input  wire logic       REF_DIV_TOGGLE,
    output logic            REF_PRESENT
);

    // ****************************************************************
    // functions
    // ****************************************************************
    // one decision per transmit port, used for both ports
    function automatic hgcs_tx_state_t tx_state_of(input logic [5:0] cfg,
                                                   input logic       any_lock);
        hgcs_tx_state_t st;
        st = HGCS_TX_NORMAL;
        if (cfg[HGCS_BIT_SLEEP_SEL] && !cfg[HGCS_BIT_TX_DRIVE])
        begin
            st = HGCS_TX_HIZ;
        end
        else if (!any_lock)
        begin
            if (!cfg[HGCS_BIT_LOCK_OUT_MODE])
            begin
                st = HGCS_TX_HIZ;
            end
            else if (!cfg[HGCS_BIT_SLEEP_SEL])
            begin
                st = HGCS_TX_HS0;
            end
            else
            begin
                st = HGCS_TX_LP11;
            end
        end
        return st;
    endfunction

    // ****************************************************************
    // general configuration register
    // ****************************************************************
    logic [5:0] cfg_q, cfg_d;
    logic       wr_cfg;

    assign wr_cfg = REG_WR && (REG_ADDR == HGCS_OFS_GENERAL_CONFIGURATION);

    always_comb
    begin
        cfg_d = cfg_q;
        if (wr_cfg)
        begin
            cfg_d = REG_WDATA[5:0] & HGCS_CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cfg_q <= HGCS_RST_GENERAL_CONFIGURATION[5:0];
        end
        else
        begin
            cfg_q <= cfg_d;
        end
    end

    // ****************************************************************
    // configuration load sequencer
    // ****************************************************************
    // load starts right after reset; a trigger mid-load is merged into it
    hgcs_load_state_t ld_q, ld_d;
    logic             done_q, done_d;
    logic             cksum_q, cksum_d;
    logic             req_q, req_d;

    always_comb
    begin
        ld_d    = ld_q;
        done_d  = done_q;
        cksum_d = cksum_q;
        req_d   = req_q;
        case (ld_q)
            HGCS_LD_START:
            begin
                done_d = 1'b0;
                req_d  = 1'b1;
                ld_d   = HGCS_LD_WAIT;
            end
            HGCS_LD_WAIT:
            begin
                if (ROM_LOAD_DONE)
                begin
                    req_d   = 1'b0;
                    done_d  = 1'b1;
                    cksum_d = ROM_CKSUM_OK;
                    ld_d    = HGCS_LD_DONE;
                end
            end
            HGCS_LD_DONE:
            begin
                if (ROM_RELOAD_TRIGGER)
                begin
                    ld_d = HGCS_LD_START;
                end
            end
            default:
            begin
                ld_d = HGCS_LD_START;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ld_q    <= HGCS_LD_START;
            done_q  <= HGCS_RST_DEVICE_STATUS[HGCS_BIT_INIT_DONE];
            cksum_q <= HGCS_RST_DEVICE_STATUS[HGCS_BIT_CKSUM_PASS];
            req_q   <= 1'b0;
        end
        else
        begin
            ld_q    <= ld_d;
            done_q  <= done_d;
            cksum_q <= cksum_d;
            req_q   <= req_d;
        end
    end

    // ****************************************************************
    // reference clock frequency check
    // ****************************************************************
    logic freq_ok;

    hgcs_ref_freq_check u_ref_chk
    (
        .clk            (MCLK),
        .rst_n          (NRST),
        .ref_div_toggle (REF_DIV_TOGGLE),
        .freq_ok        (freq_ok)
    );

    // ****************************************************************
    // outputs steered by configuration
    // ****************************************************************
    hgcs_tx_state_t tx0_q, tx0_d;
    hgcs_tx_state_t tx1_q, tx1_d;
    logic           i2c_q, i2c_d;
    logic           par_q, par_d;
    logic           refp_q, refp_d;

    always_comb
    begin
        tx0_d  = tx_state_of(cfg_q, |(RX_LOCK & TX0_RX_ASSIGN));
        tx1_d  = tx_state_of(cfg_q, |(RX_LOCK & TX1_RX_ASSIGN));
        i2c_d  = cfg_q[HGCS_BIT_I2C_CTRL_EN];
        par_d  = cfg_q[HGCS_BIT_PARITY_EN];
        refp_d = cfg_q[HGCS_BIT_REF_OVERRIDE] | REF_DETECTED;
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            tx0_q  <= HGCS_TX_HIZ;
            tx1_q  <= HGCS_TX_HIZ;
            i2c_q  <= 1'b0;
            par_q  <= 1'b0;
            refp_q <= 1'b0;
        end
        else
        begin
            tx0_q  <= tx0_d;
            tx1_q  <= tx1_d;
            i2c_q  <= i2c_d;
            par_q  <= par_d;
            refp_q <= refp_d;
        end
    end

    // ****************************************************************
    // register read
    // ****************************************************************
    // unmapped offsets read zero so probing software sees a clean bus
    logic [7:0] rdata_q, rdata_d;

    always_comb
    begin
        rdata_d = rdata_q;
        if (REG_RD)
        begin
            case (REG_ADDR)
                HGCS_OFS_GENERAL_CONFIGURATION:
                begin
                    rdata_d = {2'h0, cfg_q};
                end
                HGCS_OFS_SILICON_REVISION:
                begin
                    rdata_d = {HGCS_SILICON_REVISION_FIELD, HGCS_MASK_SET_FIELD};
                end
                HGCS_OFS_DEVICE_STATUS:
                begin
                    rdata_d = {cksum_q, done_q, 1'b0, freq_ok, 4'h0};
                end
                default:
                begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA       = rdata_q;
    assign ROM_LOAD_REQ    = req_q;
    assign TX0_STATE       = tx0_q;
    assign TX1_STATE       = tx1_q;
    assign I2C_CTRL_EN     = i2c_q;
    assign PARITY_CHECK_EN = par_q;
    assign REF_PRESENT     = refp_q;

endmodule

// >>> bench/hgcs_top_sva.sv
// assertion checker on the config and status bank ports
`timescale 1ns/1ps
module hgcs_top_sva
    import hgcs_pkg::*;
(
    input wire logic       MCLK,
    input wire logic       NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic       ROM_RELOAD_TRIGGER,
    input wire logic       ROM_LOAD_REQ,
    input wire logic       ROM_LOAD_DONE,
    input wire logic [3:0] RX_LOCK,
    input wire logic [3:0] TX0_RX_ASSIGN,
    input wire logic [1:0] TX0_STATE,
    input wire logic       I2C_CTRL_EN,
    input wire logic       PARITY_CHECK_EN,
    input wire logic       REF_DETECTED,
    input wire logic       REF_PRESENT
);
    // ****************************
    // config shadow and checks
    // ****************************
    logic [5:0] cfg_d;
    logic [5:0] cfg_q;

    function automatic logic [1:0] tx_f(logic [5:0] c, logic [3:0] l, logic [3:0] a);
        if (c[3:2] == 2'b01)
            return HGCS_TX_HIZ;
        if ((l & a) != 4'h0)
            return HGCS_TX_NORMAL;
        if (!c[4])
            return HGCS_TX_HIZ;
        return c[2] ? HGCS_TX_LP11 : HGCS_TX_HS0;
    endfunction

    always_comb
    begin
        cfg_d = cfg_q;
        if (REG_WR && REG_ADDR == HGCS_OFS_GENERAL_CONFIGURATION)
            cfg_d = REG_WDATA[5:0];
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
            cfg_q <= 6'h1E;
        else
            cfg_q <= cfg_d;
    end

    default clocking dcb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    a_i2c_en_follow: assert property ($past(NRST) |-> I2C_CTRL_EN == $past(cfg_q[5]))
        else $error("i2c enable off config");
    a_parity_follow: assert property ($past(NRST) |-> PARITY_CHECK_EN == $past(cfg_q[1]))
        else $error("parity enable off config");
    a_ref_present: assert property ($past(NRST) |->
        REF_PRESENT == ($past(cfg_q[0]) || $past(REF_DETECTED)))
        else $error("ref present wrong");
    a_tx_state_sel: assert property ($past(NRST) |->
        TX0_STATE == tx_f($past(cfg_q), $past(RX_LOCK), $past(TX0_RX_ASSIGN)))
        else $error("tx state wrong");
    a_read_cfg: assert property (REG_RD && REG_ADDR == 8'h02 |=>
        REG_RDATA == {2'b00, $past(cfg_q)})
        else $error("config read wrong");
    a_read_rev: assert property (REG_RD && REG_ADDR == 8'h03 |=>
        REG_RDATA == {HGCS_SILICON_REVISION_FIELD, HGCS_MASK_SET_FIELD})
        else $error("revision register wrong");
    a_status_rsvd: assert property (REG_RD && REG_ADDR == 8'h04 |=>
        REG_RDATA[5] == 1'b0 && REG_RDATA[3:0] == 4'h0)
        else $error("status reserved bits set");
    a_unmapped_zero: assert property (REG_RD && (REG_ADDR < 8'h02 || REG_ADDR > 8'h04) |=>
        REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_load_end: assert property (ROM_LOAD_REQ && ROM_LOAD_DONE |=> !ROM_LOAD_REQ)
        else $error("load request stuck");
    a_req_holds: assert property (ROM_LOAD_REQ && !ROM_LOAD_DONE |=> ROM_LOAD_REQ)
        else $error("load request dropped");
    a_reload_start: assert property (ROM_LOAD_REQ && ROM_LOAD_DONE ##1 ROM_RELOAD_TRIGGER
        |=> ##1 ROM_LOAD_REQ)
        else $error("reload not started");

    c_load_done: cover property (ROM_LOAD_REQ && ROM_LOAD_DONE);
    c_tx_hs0: cover property (TX0_STATE == HGCS_TX_HS0);
    c_status_rd: cover property (REG_RD && REG_ADDR == 8'h04);
endmodule

bind hgcs_top hgcs_top_sva u_sva
(
    .MCLK, .NRST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
    .ROM_RELOAD_TRIGGER, .ROM_LOAD_REQ, .ROM_LOAD_DONE, .RX_LOCK, .TX0_RX_ASSIGN,
    .TX0_STATE, .I2C_CTRL_EN, .PARITY_CHECK_EN, .REF_DETECTED, .REF_PRESENT
);

// >>> bench/tb_top.sv
// self-checking bench of the config and status bank
`timescale 1ns/1ps
module tb_top
    import hgcs_pkg::*;
;
    // ****************************
    // stimulus, model and checks
    // ****************************
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, trig = 1'b0, fq = 1'b0;
    logic        ld_done = 1'b0, ck_ok = 1'b0, ref_det = 1'b0, ref_tog = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [3:0]  lock = 4'h0, as0 = 4'h0, as1 = 4'h0;
    logic [1:0]  tx0, tx1;
    logic        ld_req, i2c, par, refp;
    logic [5:0]  cfg = 6'h1E;
    logic [15:0] lf = 16'h87B0;
    logic        ck_q [$];
    logic [7:0]  um [5] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'hFF};
    int          fails = 0, checks_done = 0, hcyc = 0, tcnt = 0;

    hgcs_top dut
    (
        .MCLK(clk), .NRST(rst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .ROM_RELOAD_TRIGGER(trig),
        .ROM_LOAD_REQ(ld_req), .ROM_LOAD_DONE(ld_done), .ROM_CKSUM_OK(ck_ok),
        .RX_LOCK(lock), .TX0_RX_ASSIGN(as0), .TX1_RX_ASSIGN(as1), .TX0_STATE(tx0),
        .TX1_STATE(tx1), .I2C_CTRL_EN(i2c), .PARITY_CHECK_EN(par),
        .REF_DETECTED(ref_det), .REF_DIV_TOGGLE(ref_tog), .REF_PRESENT(refp)
    );

    initial
    begin
        forever #25 clk = ~clk;
    end

    // divided reference: one toggle every hcyc cycles, still while hcyc is 0
    always
    begin
        @(posedge clk);
        #2;
        tcnt++;
        if (hcyc > 0 && tcnt % hcyc == 0)
            ref_tog = ~ref_tog;
    end

    function automatic logic [15:0] nx(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [1:0] txm(logic [3:0] a);
        if (cfg[3:2] == 2'b01)
            return HGCS_TX_HIZ;
        if ((lock & a) != 4'h0)
            return HGCS_TX_NORMAL;
        if (!cfg[4])
            return HGCS_TX_HIZ;
        return cfg[2] ? HGCS_TX_LP11 : HGCS_TX_HS0;
    endfunction

    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    // one strobe cycle then an idle cycle, so strobes never toggle twice at once
    task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        cyc(1);
        wr = 1'b0;
        rd = 1'b0;
        cyc(1);
    endtask

    task automatic trg();
        trig = 1'b1;
        cyc(1);
        trig = 1'b0;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic load(logic ok);
        repeat (8)
            if (ld_req !== 1'b1)
                cyc(1);
        chk("load request", 8'h01, 8'(ld_req));
        if (ld_req !== 1'b1)
            end_of_test();
        bus(0, HGCS_OFS_DEVICE_STATUS, 8'h00);
        chk("init done busy", 8'h00, rdata & 8'h40);
        trg();
        ck_ok = ok;
        ld_done = 1'b1;
        cyc(1);
        ld_done = 1'b0;
        ck_q.push_back(ok);
    endtask

    // model keeps the checksum verdict of every finished load; the last one must show
    task automatic stat();
        bus(0, HGCS_OFS_DEVICE_STATUS, 8'h00);
        chk("status", {ck_q[$], 2'b10, fq, 4'h0}, rdata);
        chk("load idle", 8'h00, 8'(ld_req));
    endtask

    initial
    begin
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
        chk("i2c reset", 8'h00, 8'(i2c));
        chk("parity reset", 8'h01, 8'(par));
        bus(0, HGCS_OFS_GENERAL_CONFIGURATION, 8'h00);
        chk("config reset", 8'h1E, rdata);
        bus(0, HGCS_OFS_SILICON_REVISION, 8'h00);
        chk("revision", {HGCS_SILICON_REVISION_FIELD, 4'h0}, rdata);
        load(1'b0);
        stat();
        trg();
        load(1'b1);
        trg();
        load(1'b1);
        stat();
        bus(1, HGCS_OFS_SILICON_REVISION, 8'hFF);
        bus(1, HGCS_OFS_DEVICE_STATUS, 8'hFF);
        bus(1, 8'h07, 8'hFF);
        bus(0, HGCS_OFS_GENERAL_CONFIGURATION, 8'h00);
        chk("config kept", 8'h1E, rdata);
        stat();
        foreach (um[k])
        begin
            bus(0, um[k], 8'h00);
            chk("unmapped", 8'h00, rdata);
        end
        for (int i = 0; i < 64; i++)
        begin
            lf = nx(lf);
            cfg = 6'(i);
            {ref_det, as1, as0, lock} = lf[12:0];
            bus(1, HGCS_OFS_GENERAL_CONFIGURATION, {lf[15:14], cfg});
            bus(0, HGCS_OFS_GENERAL_CONFIGURATION, 8'h00);
            chk("config", {2'b00, cfg}, rdata);
            chk("i2c enable", 8'(cfg[5]), 8'(i2c));
            chk("parity enable", 8'(cfg[1]), 8'(par));
            chk("ref present", 8'(cfg[0] | ref_det), 8'(refp));
            chk("tx0", 8'(txm(as0)), 8'(tx0));
            chk("tx1", 8'(txm(as1)), 8'(tx1));
        end
        // reference at 320/hcyc MHz, below and near the lower limit, inside, and above the upper limit
        // a full window must pass before the bit moves
        for (int h = 34; h > 0; h -= 8)
        begin
            hcyc = h;
            cyc(2100);
            fq = (320 / hcyc) inside {[12:64]};
            stat();
        end
        end_of_test();
    end
endmodule
